//--- logic/mode_regs_pkg.sv
/*
 * Shared constants and state types for the calibration-invert, refresh-mask
 * and strobe-oscillator-count mode registers.
 * Assumes a single die with two channels sharing one command link.
 */
package mode_regs_pkg;

  // ==========================================================================
  // geometry
  localparam int unsigned NUM_CHAN   = 2;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned OP_W       = 8;
  localparam int unsigned CNT_W      = 16;

  // ==========================================================================
  // mode register addresses
  localparam logic [5:0]  ADDR_LO_INV = 6'h0F;
  localparam logic [5:0]  ADDR_BANK   = 6'h10;
  localparam logic [5:0]  ADDR_SEG    = 6'h11;
  localparam logic [5:0]  ADDR_CNT_LO = 6'h12;
  localparam logic [5:0]  ADDR_CNT_HI = 6'h13;
  localparam logic [5:0]  ADDR_HI_INV = 6'h14;

  // ==========================================================================
  // reset values and fixed words
  localparam logic [7:0]  INV_RESET   = 8'h55;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  localparam logic [7:0]  RD_ZERO     = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] NO_INVERT   = 16'h0000;

  // ==========================================================================
  // commands carried from the link side to the core side
  typedef enum logic [1:0] {
    CMD_MRW,
    CMD_OSC_START,
    CMD_OSC_STOP
  } cmd_kind_t;

  typedef struct packed {
    logic       cmd_tgl;
    cmd_kind_t  cmd_kind;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_data;
    logic       cmd_chan;
    logic [1:0] ack_sync;
    logic [2:0] cnt_sync;
    logic       cnt_ack_tgl;
    logic [15:0] count;
    logic [7:0] rd_dq;
    logic       rd_valid;
  } link_state_t;

  typedef struct packed {
    logic [2:0]                 cmd_sync;
    logic                       cmd_ack_tgl;
    logic [7:0]                 inv_lo;
    logic [7:0]                 inv_hi;
    logic [NUM_CHAN-1:0][7:0]   bank_mask;
    logic [NUM_CHAN-1:0][7:0]   seg_mask;
    logic                       osc_run;
    logic [15:0]                osc_count;
    logic                       cnt_tgl;
    logic [15:0]                cnt_word;
    logic [1:0]                 cnt_ack_sync;
    logic [15:0]                cal_dq;
    logic [1:0]                 cal_dmi;
    logic                       dbi_apply;
    logic                       ref_skip;
  } core_state_t;

endpackage : mode_regs_pkg

//--- logic/xfer_if.sv
/*
 * Crossing bundle between the link-clock side and the core-clock side.
 * Assumes both ends use toggle handshakes and hold data until acknowledged.
 */
`timescale 1ns/1ps
interface xfer_if;
  logic                    cmd_tgl;
  mode_regs_pkg::cmd_kind_t cmd_kind;
  logic [5:0]              cmd_addr;
  logic [7:0]              cmd_data;
  logic                    cmd_chan;
  logic                    cmd_ack_tgl;
  logic                    cnt_tgl;
  logic [15:0]             cnt_word;
  logic                    cnt_ack_tgl;

  modport link (output cmd_tgl, cmd_kind, cmd_addr, cmd_data, cmd_chan, cnt_ack_tgl,
                input  cmd_ack_tgl, cnt_tgl, cnt_word);
  modport core (input  cmd_tgl, cmd_kind, cmd_addr, cmd_data, cmd_chan, cnt_ack_tgl,
                output cmd_ack_tgl, cnt_tgl, cnt_word);
endinterface : xfer_if

//--- logic/link_side.sv
/*
 * Link-clock end: takes mode register writes/reads and oscillator commands,
 * forwards commands to the core side, answers reads of the count registers.
 * Assumes commands are spaced so each handshake completes before the next.
 */
`timescale 1ns/1ps
module link_side (
  input  wire logic       mem_ck_i,
  input  wire logic       rst_b_i,
  input  wire logic       mr_wr_i,
  input  wire logic       mr_rd_i,
  input  wire logic [5:0] mr_addr_i,
  input  wire logic [7:0] mr_op_i,
  input  wire logic       mr_chan_i,
  input  wire logic       osc_start_i,
  input  wire logic       osc_stop_i,
  xfer_if.link            xf,
  output logic      [7:0] mrr_dq_o,
  output logic            mrr_valid_o
);

  mode_regs_pkg::link_state_t q;
  mode_regs_pkg::link_state_t d;
  logic                       busy;

  assign busy = q.cmd_tgl != q.ack_sync[1];

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.ack_sync = {q.ack_sync[0], xf.cmd_ack_tgl};
    d.cnt_sync = {q.cnt_sync[1:0], xf.cnt_tgl};
    d.rd_valid = mr_rd_i;
    d.rd_dq    = mode_regs_pkg::RD_ZERO;
    if (mr_rd_i) begin
      case (mr_addr_i)
        mode_regs_pkg::ADDR_CNT_LO: d.rd_dq = q.count[7:0];
        mode_regs_pkg::ADDR_CNT_HI: d.rd_dq = q.count[15:8];
        default:                    d.rd_dq = mode_regs_pkg::RD_ZERO;
      endcase
    end
    if (q.cnt_sync[2] ^ q.cnt_sync[1]) begin
      d.count       = xf.cnt_word;
      d.cnt_ack_tgl = q.cnt_sync[1];
    end
    // a command arriving while the previous is still in flight is dropped
    if (!busy && (osc_start_i || osc_stop_i || mr_wr_i)) begin
      d.cmd_tgl  = ~q.cmd_tgl;
      d.cmd_addr = mr_addr_i;
      d.cmd_data = mr_op_i;
      d.cmd_chan = mr_chan_i;
      if (osc_start_i) begin
        d.cmd_kind = mode_regs_pkg::CMD_OSC_START;
      end else if (osc_stop_i) begin
        d.cmd_kind = mode_regs_pkg::CMD_OSC_STOP;
      end else begin
        d.cmd_kind = mode_regs_pkg::CMD_MRW;
      end
    end
    // start clears the readable count at once, ahead of any update in flight
    if (osc_start_i) begin
      d.count = mode_regs_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge mem_ck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign xf.cmd_tgl     = q.cmd_tgl;
  assign xf.cmd_kind    = q.cmd_kind;
  assign xf.cmd_addr    = q.cmd_addr;
  assign xf.cmd_data    = q.cmd_data;
  assign xf.cmd_chan    = q.cmd_chan;
  assign xf.cnt_ack_tgl = q.cnt_ack_tgl;
  assign mrr_dq_o       = q.rd_dq;
  assign mrr_valid_o    = q.rd_valid;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mem_ck_i); endclocking
  default disable iff (!rst_b_i);

  sequence rd_lo_s;
    mr_rd_i && mr_addr_i == mode_regs_pkg::ADDR_CNT_LO && !(q.cnt_sync[2] ^ q.cnt_sync[1]);
  endsequence

  count_low_read_a: assert property (rd_lo_s |=> mrr_valid_o && mrr_dq_o == $past(q.count[7:0]))
    else $error("count low byte read mismatch");
  count_high_read_a: assert property (mr_rd_i && mr_addr_i == mode_regs_pkg::ADDR_CNT_HI
      |=> mrr_valid_o && mrr_dq_o == $past(q.count[15:8]))
    else $error("count high byte read mismatch");
  other_read_zero_a: assert property (mr_rd_i && mr_addr_i != mode_regs_pkg::ADDR_CNT_LO
      && mr_addr_i != mode_regs_pkg::ADDR_CNT_HI |=> mrr_valid_o && mrr_dq_o == 8'h00)
    else $error("unreadable register did not read zero");
  link_start_clear_a: assert property (osc_start_i |=> q.count == 16'h0000)
    else $error("start did not clear the readable count");
  read_idle_zero_a: assert property (!mr_rd_i |=> !mrr_valid_o && mrr_dq_o == 8'h00)
    else $error("read lanes not zero outside a read answer");

endmodule : link_side

//--- logic/calib_mode_regs.sv
/*
 * Calibration-invert, refresh-mask and strobe-oscillator-count mode registers.
 * Core side runs on ref_clk_i; the command link runs on mem_ck_i via link_side.
 * Assumes core-side inputs come from logic on ref_clk_i and that link inputs
 * are synchronous to mem_ck_i.
 */
//
// Summary of operation
// - lower inversion bit n set inverts calibration pattern on low lane n.
// - lower inversion register resets to 0x55.
// - low data-mask lane always carries the true calibration pattern.
// - bus inversion is never applied to calibration output.
// - upper inversion bit n inverts lane 8+n; resets to 0x55.
// - bank mask bit n set stops refresh of bank n; reset clear.
// - bank mask held separately per channel.
// - segment mask bit n set stops refresh of rows with row bits 13:11 = n.
// - segment mask held separately per channel.
// - count low register reads low byte of oscillator count.
// - count high register reads high byte of oscillator count.
// - oscillator start command clears both count registers.
// - addresses 0x0F to 0x14 select lower inversion, bank mask, segment mask, count low, count high, upper inversion.
// - high data-mask lane always carries the true calibration pattern.
// - read of a count register places its bits on lanes 7:0; other addresses read zero.
`timescale 1ns/1ps
module calib_mode_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        mem_ck_i,
  input  wire logic        mr_wr_i,
  input  wire logic        mr_rd_i,
  input  wire logic [5:0]  mr_addr_i,
  input  wire logic [7:0]  mr_op_i,
  input  wire logic        mr_chan_i,
  input  wire logic        osc_start_i,
  input  wire logic        osc_stop_i,
  output logic      [7:0]  mrr_dq_o,
  output logic             mrr_valid_o,
  input  wire logic        osc_tick_i,
  output logic             osc_running_o,
  input  wire logic        cal_en_i,
  input  wire logic [15:0] cal_pattern_i,
  input  wire logic [1:0]  cal_dmi_i,
  input  wire logic        dbi_en_i,
  output logic      [15:0] cal_dq_o,
  output logic      [1:0]  cal_dmi_o,
  output logic             dbi_apply_o,
  input  wire logic        ref_chan_i,
  input  wire logic [2:0]  ref_bank_i,
  input  wire logic [2:0]  ref_row_seg_i,
  output logic             refresh_skip_o,
  output logic      [15:0] bank_mask_o,
  output logic      [15:0] seg_mask_o
);

  // ==========================================================================
  // helpers
  function automatic logic mask_hit(input logic [7:0] mask, input logic [2:0] idx);
    mask_hit = mask[idx];
  endfunction : mask_hit

  mode_regs_pkg::core_state_t q;
  mode_regs_pkg::core_state_t d;
  xfer_if                     xf ();
  logic                       new_cmd;
  logic                       cnt_idle;

  // ==========================================================================
  // link end
  link_side u_link (
    .mem_ck_i    (mem_ck_i),
    .rst_b_i     (rst_b_i),
    .mr_wr_i     (mr_wr_i),
    .mr_rd_i     (mr_rd_i),
    .mr_addr_i   (mr_addr_i),
    .mr_op_i     (mr_op_i),
    .mr_chan_i   (mr_chan_i),
    .osc_start_i (osc_start_i),
    .osc_stop_i  (osc_stop_i),
    .xf          (xf.link),
    .mrr_dq_o    (mrr_dq_o),
    .mrr_valid_o (mrr_valid_o)
  );

  // command fields are held by the link end until our acknowledge returns,
  // so they are stable whenever the synchronised toggle shows a change
  assign new_cmd  = q.cmd_sync[2] ^ q.cmd_sync[1];
  assign cnt_idle = q.cnt_tgl == q.cnt_ack_sync[1];

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.cmd_sync     = {q.cmd_sync[1:0], xf.cmd_tgl};
    d.cnt_ack_sync = {q.cnt_ack_sync[0], xf.cnt_ack_tgl};

    // saturate instead of wrapping so a long run never reads as a short one
    if (osc_tick_i && q.osc_run && q.osc_count != mode_regs_pkg::CNT_MAX) begin
      d.osc_count = q.osc_count + mode_regs_pkg::CNT_ONE;
    end

    if (new_cmd) begin
      d.cmd_ack_tgl = q.cmd_sync[1];
      case (xf.cmd_kind)
        mode_regs_pkg::CMD_OSC_START: begin
          d.osc_run   = 1'b1;
          d.osc_count = mode_regs_pkg::CNT_RESET;
        end
        mode_regs_pkg::CMD_OSC_STOP: begin
          d.osc_run = 1'b0;
        end
        default: begin
          case (xf.cmd_addr)
            mode_regs_pkg::ADDR_LO_INV: d.inv_lo = xf.cmd_data;
            mode_regs_pkg::ADDR_HI_INV: d.inv_hi = xf.cmd_data;
            mode_regs_pkg::ADDR_BANK:   d.bank_mask[xf.cmd_chan] = xf.cmd_data;
            mode_regs_pkg::ADDR_SEG:    d.seg_mask[xf.cmd_chan] = xf.cmd_data;
            default: begin
              // count registers are read-only; unmapped addresses are ignored
            end
          endcase
        end
      endcase
    end

    // publish the count to the link end once the last copy is acknowledged and the count differs from it
    if (cnt_idle && q.cnt_word != q.osc_count) begin
      d.cnt_word = q.osc_count;
      d.cnt_tgl  = ~q.cnt_tgl;
    end

    d.cal_dq    = cal_pattern_i ^ (cal_en_i ? {q.inv_hi, q.inv_lo}
                                            : mode_regs_pkg::NO_INVERT);
    d.cal_dmi   = cal_dmi_i;
    d.dbi_apply = dbi_en_i & ~cal_en_i;
    d.ref_skip  = mask_hit(q.bank_mask[ref_chan_i], ref_bank_i)
                | mask_hit(q.seg_mask[ref_chan_i], ref_row_seg_i);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q        <= '0;
      q.inv_lo <= mode_regs_pkg::INV_RESET;
      q.inv_hi <= mode_regs_pkg::INV_RESET;
    end else begin
      q <= d;
    end
  end

  assign xf.cmd_ack_tgl = q.cmd_ack_tgl;
  assign xf.cnt_tgl     = q.cnt_tgl;
  assign xf.cnt_word    = q.cnt_word;

  assign osc_running_o  = q.osc_run;
  assign cal_dq_o       = q.cal_dq;
  assign cal_dmi_o      = q.cal_dmi;
  assign dbi_apply_o    = q.dbi_apply;
  assign refresh_skip_o = q.ref_skip;
  assign bank_mask_o    = q.bank_mask;
  assign seg_mask_o     = q.seg_mask;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence mrw_s(logic [5:0] addr);
    new_cmd && xf.cmd_kind == mode_regs_pkg::CMD_MRW && xf.cmd_addr == addr;
  endsequence

  sequence start_s;
    new_cmd && xf.cmd_kind == mode_regs_pkg::CMD_OSC_START;
  endsequence

  inv_reset_value_a: assert property (!$past(rst_b_i) |->
      q.inv_lo == 8'h55 && q.inv_hi == 8'h55)
    else $error("inversion registers not 0x55 after reset");
  lo_lane_invert_a: assert property (cal_en_i |=>
      cal_dq_o[7:0] == ($past(cal_pattern_i[7:0]) ^ $past(q.inv_lo)))
    else $error("low byte calibration inversion wrong");
  hi_lane_invert_a: assert property (cal_en_i |=>
      cal_dq_o[15:8] == ($past(cal_pattern_i[15:8]) ^ $past(q.inv_hi)))
    else $error("high byte calibration inversion wrong");
  dmi_true_data_a: assert property (cal_en_i |=> cal_dmi_o == $past(cal_dmi_i))
    else $error("data mask lane altered during calibration");
  no_bus_invert_a: assert property (cal_en_i && dbi_en_i |=> !dbi_apply_o)
    else $error("bus inversion applied during calibration");
  lo_write_apply_a: assert property (mrw_s(mode_regs_pkg::ADDR_LO_INV) ##1 1'b1
      |-> q.inv_lo == $past(xf.cmd_data))
    else $error("lower inversion write not applied");
  bank_chan_write_a: assert property (mrw_s(mode_regs_pkg::ADDR_BANK)
      |=> q.bank_mask[$past(xf.cmd_chan)] == $past(xf.cmd_data)
          && q.bank_mask[!$past(xf.cmd_chan)] == $past(q.bank_mask[!xf.cmd_chan]))
    else $error("bank mask write hit the wrong channel");
  hi_write_apply_a: assert property (mrw_s(mode_regs_pkg::ADDR_HI_INV)
      |=> q.inv_hi == $past(xf.cmd_data))
    else $error("upper inversion write not applied");
  ro_write_ignore_a: assert property (mrw_s(mode_regs_pkg::ADDR_CNT_LO)
      |=> $stable(q.inv_lo) && $stable(q.inv_hi)
          && $stable(q.bank_mask) && $stable(q.seg_mask))
    else $error("write to a read-only address changed a register");
  seg_chan_write_a: assert property (mrw_s(mode_regs_pkg::ADDR_SEG)
      |=> q.seg_mask[$past(xf.cmd_chan)] == $past(xf.cmd_data))
    else $error("segment mask write not applied");
  refresh_skip_a: assert property (1'b1 |=> refresh_skip_o ==
      (mask_hit($past(q.bank_mask[ref_chan_i]), $past(ref_bank_i))
       | mask_hit($past(q.seg_mask[ref_chan_i]), $past(ref_row_seg_i))))
    else $error("refresh skip does not follow the masks");
  osc_start_clear_a: assert property (start_s |=> q.osc_count == 16'h0000 && q.osc_run)
    else $error("start did not clear the oscillator count");
  osc_tick_count_a: assert property (osc_tick_i && q.osc_run && !new_cmd
      && q.osc_count != 16'hFFFF |=> q.osc_count == $past(q.osc_count) + 16'h0001)
    else $error("running oscillator tick not counted");
  osc_stop_freeze_a: assert property (!q.osc_run && !new_cmd
      |=> $stable(q.osc_count))
    else $error("stopped oscillator count moved");
  count_publish_a: assert property (cnt_idle && q.cnt_word != q.osc_count
      |=> q.cnt_word == $past(q.osc_count) && !cnt_idle)
    else $error("changed count not published to the link side");

endmodule : calib_mode_regs

//--- dv/ctrl_model.sv
/*
 * Controller-side model of the mode register command link.
 * Assumes the device answers reads one mem_ck_i cycle after the request.
 */
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic       mem_ck_i,
  input  wire logic [7:0] mrr_dq_i,
  input  wire logic       mrr_valid_i,
  output logic            mr_wr_o,
  output logic            mr_rd_o,
  output logic      [5:0] mr_addr_o,
  output logic      [7:0] mr_op_o,
  output logic            mr_chan_o,
  output logic            osc_start_o,
  output logic            osc_stop_o
);
  // ==========================================================================
  // idle values
  initial begin
    mr_wr_o     = 1'b0;
    mr_rd_o     = 1'b0;
    mr_addr_o   = 6'h3F;
    mr_op_o     = 8'hA5;
    mr_chan_o   = 1'b0;
    osc_start_o = 1'b0;
    osc_stop_o  = 1'b0;
  end

  // ==========================================================================
  // commands
  task automatic mr_write(input logic [5:0] a, input logic [7:0] d, input logic c);
    @(posedge mem_ck_i);
    mr_wr_o   <= 1'b1;
    mr_addr_o <= a;
    mr_op_o   <= d;
    mr_chan_o <= c;
    @(posedge mem_ck_i);
    mr_wr_o   <= 1'b0;
    // operand no longer valid: never echo the last value
    mr_op_o   <= ~d;
    mr_addr_o <= ~a;
    // gap long enough for the crossing handshake to finish
    repeat (7) @(posedge mem_ck_i);
  endtask : mr_write

  task automatic osc_cmd(input logic start);
    @(posedge mem_ck_i);
    osc_start_o <= start;
    osc_stop_o  <= ~start;
    @(posedge mem_ck_i);
    osc_start_o <= 1'b0;
    osc_stop_o  <= 1'b0;
    repeat (7) @(posedge mem_ck_i);
  endtask : osc_cmd

  task automatic mr_read(input logic [5:0] a, output logic [7:0] d, output logic ok);
    @(posedge mem_ck_i);
    mr_rd_o   <= 1'b1;
    mr_addr_o <= a;
    @(posedge mem_ck_i);
    mr_rd_o   <= 1'b0;
    mr_addr_o <= ~a;
    #1;
    ok = mrr_valid_i;
    d  = mrr_dq_i;
  endtask : mr_read

  // both bytes needed; high byte forms bits 15:8
  // a fresh start precedes each measurement by the caller
  task automatic read_count(output logic [15:0] cnt, output logic ok);
    logic ok_hi;
    logic ok_lo;
    mr_read(6'h13, cnt[15:8], ok_hi);
    mr_read(6'h12, cnt[7:0], ok_lo);
    ok = ok_hi & ok_lo;
  endtask : read_count
endmodule : ctrl_model

//--- dv/tb_top.sv
/*
 * Self-checking bench for the calibration-invert, refresh-mask and
 * oscillator-count registers; core side driven here, link side by ctrl_model.
 */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0, mem_ck = 1'b0;
  logic mr_wr, mr_rd, mr_chan, osc_start, osc_stop, mrr_valid, osc_running;
  logic [5:0] mr_addr;
  logic [7:0] mr_op, mrr_dq;
  logic tick = 1'b0, cal_en = 1'b0, dbi_en = 1'b0, dbi_apply, ref_chan = 1'b0, skip;
  logic [15:0] pattern = 16'h0000, cal_dq, bank_mask, seg_mask;
  logic [1:0] dmi = 2'b00, cal_dmi;
  logic [2:0] ref_bank = 3'h0, ref_seg = 3'h0;
  int n_fail = 0, n_checks = 0;

  always #2 ref_clk = ~ref_clk;
  // link clock quiet through reset, then free with an unrelated phase
  initial begin
    @(posedge rst_b);
    #13.7;
    forever #32 mem_ck = ~mem_ck;
  end

  calib_mode_regs calib_mode_regs_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .mem_ck_i(mem_ck), .mr_wr_i(mr_wr), .mr_rd_i(mr_rd), .mr_addr_i(mr_addr),
    .mr_op_i(mr_op), .mr_chan_i(mr_chan), .osc_start_i(osc_start),
    .osc_stop_i(osc_stop), .mrr_dq_o(mrr_dq), .mrr_valid_o(mrr_valid),
    .osc_tick_i(tick), .osc_running_o(osc_running), .cal_en_i(cal_en),
    .cal_pattern_i(pattern), .cal_dmi_i(dmi), .dbi_en_i(dbi_en), .cal_dq_o(cal_dq),
    .cal_dmi_o(cal_dmi), .dbi_apply_o(dbi_apply), .ref_chan_i(ref_chan),
    .ref_bank_i(ref_bank), .ref_row_seg_i(ref_seg), .refresh_skip_o(skip),
    .bank_mask_o(bank_mask), .seg_mask_o(seg_mask));

  ctrl_model ctrl_model_inst (.mem_ck_i(mem_ck), .mrr_dq_i(mrr_dq),
    .mrr_valid_i(mrr_valid), .mr_wr_o(mr_wr), .mr_rd_o(mr_rd), .mr_addr_o(mr_addr),
    .mr_op_o(mr_op), .mr_chan_o(mr_chan), .osc_start_o(osc_start),
    .osc_stop_o(osc_stop));

  // ==========================================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic rcyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : rcyc

  // tick pulses, then time for the last count copy to reach the link end
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
    repeat (8) @(posedge mem_ck);
  endtask : ticks

  task automatic read_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    ctrl_model_inst.mr_read(a, d, ok);
    check({15'h0000, ok}, 16'h0001, "read valid");
    check({8'h00, d}, {8'h00, exp}, "read data");
  endtask : read_chk

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    @(posedge ref_clk);
    cal_en  <= 1'b1;
    pattern <= 16'h0000;
    rcyc(2);
    check(cal_dq, 16'h5555, "invert reset");
    check(bank_mask, 16'h0000, "bank reset");
    check(seg_mask, 16'h0000, "seg reset");
    read_chk(6'h0F, 8'h00);
    read_chk(6'h12, 8'h00);
    read_chk(6'h13, 8'h00);
    read_chk(6'h3F, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_invert;
    ctrl_model_inst.mr_write(6'h0F, 8'h15, 1'b0);
    ctrl_model_inst.mr_write(6'h14, 8'hA3, 1'b1);
    @(posedge ref_clk);
    pattern <= 16'hFFFF;
    dmi     <= 2'b11;
    dbi_en  <= 1'b1;
    rcyc(2);
    check(cal_dq, 16'hFFFF ^ {8'hA3, 8'h15}, "invert ones");
    check({14'h0000, cal_dmi}, 16'h0003, "mask lanes");
    check({15'h0000, dbi_apply}, 16'h0000, "no dbi");
    @(posedge ref_clk);
    pattern <= 16'h0F0F;
    dmi     <= 2'b01;
    rcyc(2);
    check(cal_dq, 16'h0F0F ^ {8'hA3, 8'h15}, "invert mixed");
    check({14'h0000, cal_dmi}, 16'h0001, "mask lanes");
    @(posedge ref_clk);
    cal_en <= 1'b0;
    rcyc(2);
    check(cal_dq, 16'h0F0F, "plain pattern");
    check({15'h0000, dbi_apply}, 16'h0001, "dbi outside cal");
    $display("test invert done");
  endtask : t_invert

  task automatic t_masks;
    logic [1:0][7:0] bm;
    logic [1:0][7:0] sm;
    bm = {8'h02, 8'h81};
    sm = {8'h00, 8'h10};
    ctrl_model_inst.mr_write(6'h10, 8'h81, 1'b0);
    ctrl_model_inst.mr_write(6'h10, 8'h02, 1'b1);
    ctrl_model_inst.mr_write(6'h11, 8'h10, 1'b0);
    ctrl_model_inst.mr_write(6'h15, 8'hFF, 1'b0);
    ctrl_model_inst.mr_write(6'h12, 8'hFF, 1'b1);
    check(bank_mask, bm, "bank per chan");
    check(seg_mask, sm, "seg per chan");
    read_chk(6'h12, 8'h00);
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge ref_clk);
        ref_chan <= c[0];
        ref_bank <= i[2:0];
        ref_seg  <= 3'(7 - i);
        rcyc(2);
        check({15'h0000, skip}, {15'h0000, bm[c][i] | sm[c][7 - i]}, "skip");
      end
    end
    $display("test masks done");
  endtask : t_masks

  task automatic t_osc;
    logic [15:0] cnt;
    logic        ok;
    ctrl_model_inst.osc_cmd(1'b1);
    check({15'h0000, osc_running}, 16'h0001, "running");
    ticks(300);
    ctrl_model_inst.osc_cmd(1'b0);
    check({15'h0000, osc_running}, 16'h0000, "stopped");
    ticks(20);
    ctrl_model_inst.read_count(cnt, ok);
    check(cnt, 16'h012C, "count");
    check({15'h0000, ok}, 16'h0001, "count valid");
    ctrl_model_inst.osc_cmd(1'b1);
    check({15'h0000, osc_running}, 16'h0001, "restarted");
    ctrl_model_inst.read_count(cnt, ok);
    check(cnt, 16'h0000, "count cleared");
    ticks(5);
    ctrl_model_inst.read_count(cnt, ok);
    check(cnt, 16'h0005, "count after restart");
    $display("test osc done");
  endtask : t_osc

  // ==========================================================================
  // run control
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // whole run is about 12 us; eight times that means a hang
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mem_ck);
    t_reset();
    t_invert();
    t_masks();
    t_osc();
    stop_test();
  end
endmodule : tb_top
